/* File: rtl/pcmp_pkg.sv */
// Purpose: constants for the second phy control register and mmd portal
// Assumes: clause-22 management frames, 16-bit registers
// Notes: register offsets are 5-bit management register numbers
package pcmp_pkg;

    // ==========================================================
    // register numbers
    localparam logic [4:0] REG_IND_CTRL = 5'h0d;
    localparam logic [4:0] REG_IND_DATA = 5'h0e;
    localparam logic [4:0] REG_CTL2 = 5'h1f;

    // ==========================================================
    // phy control two fields
    localparam int CTL2_ALGO = 15;
    localparam int CTL2_MDIX = 14;
    localparam int CTL2_XOFF = 13;
    localparam int CTL2_FLINK = 11;
    localparam int CTL2_PSAVE = 10;
    localparam int CTL2_IPOL = 9;
    localparam int CTL2_JAB = 8;
    localparam int CTL2_LED_LO = 4;
    localparam int CTL2_TXOFF = 3;
    localparam int CTL2_RLOOP = 2;
    localparam int CTL2_SQE = 1;
    localparam int CTL2_SCRB = 0;
    // reset value without the strap bit and the led field
    localparam logic [15:0] CTL2_RST = 16'h8100;
    localparam logic [1:0] LED_SPD_LNKACT = 2'b00;
    localparam logic [1:0] LED_ACT_LNK = 2'b01;

    // ==========================================================
    // portal control fields
    localparam int FN_HI = 15;
    localparam int FN_LO = 14;
    localparam int DEV_W = 5;
    localparam logic [1:0] FN_ADDR = 2'b00;
    localparam logic [1:0] FN_DATA = 2'b01;
    localparam logic [1:0] FN_INC_RW = 2'b10;
    localparam logic [1:0] FN_INC_WR = 2'b11;
    localparam logic [15:0] IND_CTRL_RST = 16'h0000;
    localparam logic [15:0] IND_ADDR_RST = 16'h0000;

    // ==========================================================
    // management frame
    localparam int PRE_LEN = 32;
    localparam int HDR_BITS = 13;
    localparam int DATA_BITS = 16;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam int STRAP_WAIT = 3;

    typedef enum {ST_PRE, ST_HDR, ST_TA, ST_WDATA, ST_RDATA} pcmp_state_t;

endpackage : pcmp_pkg

/* File: rtl/pcmp_regs.sv */
// Purpose: phy control two register and indirect mmd portal behind mdio
// Assumes: mdc slower than clk_in / 4; mdio sampled on mdc rising edges
// Notes: only a small window of mmd storage is built, see MMD_AW
// What this block does
// - bit 15 selects crossover algorithm, resets one
// - bit 14 forces mdi-x when auto off
// - bit 13 disables auto crossover, strap reset
// - bit 11 forces link pass
// - bit 10 enables power saving
// - bit 9 sets interrupt pin polarity
// - bit 8 enables jabber counter, resets one
// - led field maps speed, link, activity
// - bit 3 disables transmitter
// - bit 2 enables remote analog loopback
// - bit 1 enables sqe test
// - bit 0 bypasses scrambler
// - 32 devices of 8 stored 16-bit registers each (MMD_AW = 3)
// - function 00 address, 01 data no increment
// - 10 increments on all, 11 writes only
// - low five control bits pick device
// - data register reaches address or data
module pcmp_regs
#(
    parameter logic [4:0] PHY_ADDR = 5'h01,
    parameter logic [1:0] LED_MODE_RST = pcmp_pkg::LED_ACT_LNK,
    parameter int MMD_AW = 3
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // management pins
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n_out,
    // strap and status from the phy
    input wire logic strap_xover_off_in,
    input wire logic auto_mdix_in,
    input wire logic speed_in,
    input wire logic link_in,
    input wire logic activity_in,
    input wire logic irq_event_in,
    // controls to the phy
    output logic crossover_algo_select_out,
    output logic mdix_active_out,
    output logic xover_disable_out,
    output logic force_link_out,
    output logic power_save_out,
    output logic jabber_en_out,
    output logic tx_disable_out,
    output logic remote_loop_out,
    output logic sqe_test_out,
    output logic scramble_bypass_out,
    // indicators
    output logic led0_out,
    output logic led1_out,
    output logic irq_pin_out
);
    import pcmp_pkg::*;

    localparam int NDEV = 1 << DEV_W;
    localparam int MEM_N = NDEV << MMD_AW;

    // ==========================================================
    // pin synchronisers
    logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2, strap_s1, strap_s2;
    logic mdc_rise;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mdc_s1 <= 1'b0;
            mdc_s2 <= 1'b0;
            mdc_s3 <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
        end
        else
        begin
            mdc_s1 <= mdc_in;
            mdc_s2 <= mdc_s1;
            mdc_s3 <= mdc_s2;
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
            strap_s1 <= strap_xover_off_in;
            strap_s2 <= strap_s1;
        end
    end

    assign mdc_rise = mdc_s2 & ~mdc_s3;

    // ==========================================================
    // register state
    logic [15:0] ctl2;
    logic [15:0] ind_ctrl;
    logic [15:0] ind_addr [NDEV];
    logic [15:0] mmd_mem [MEM_N];
    logic [4:0] indirect_device_number;
    int cur_idx;
    logic [1:0] func;
    logic [15:0] cur_addr;
    logic [15:0] rd_value;

    assign indirect_device_number = ind_ctrl[DEV_W-1:0];
    assign func = ind_ctrl[FN_HI:FN_LO];
    assign cur_addr = ind_addr[indirect_device_number];

    // only the low MMD_AW address bits of each device are stored
    function automatic logic in_window(input logic [15:0] a);
        in_window = (a >> MMD_AW) == 16'h0000;
    endfunction : in_window

    function automatic int mem_idx(input logic [4:0] d,
                                   input logic [15:0] a);
        mem_idx = (int'(d) << MMD_AW) | int'(a[MMD_AW-1:0]);
    endfunction : mem_idx

    assign cur_idx = mem_idx(indirect_device_number, cur_addr);

    // ==========================================================
    // frame engine
    pcmp_state_t state;
    logic [5:0] ones;
    logic [4:0] bitcnt;
    logic [11:0] hdr;
    logic [12:0] next_hdr;
    logic [15:0] shift;
    logic [4:0] acc_reg;
    logic hdr_read, hdr_write;
    logic wr_stb, rd_stb;
    logic [15:0] wr_data;

    assign next_hdr = {hdr, mdio_s2};
    assign hdr_read = next_hdr[12] && next_hdr[11:10] == OP_READ
                      && next_hdr[9:5] == PHY_ADDR;
    assign hdr_write = next_hdr[12] && next_hdr[11:10] == OP_WRITE
                       && next_hdr[9:5] == PHY_ADDR;

    // read value; unmapped registers read zero
    always_comb
    begin
        rd_value = 16'h0000;
        case (next_hdr[4:0])
            REG_IND_CTRL: rd_value = ind_ctrl;
            REG_IND_DATA:
            begin
                if (func == FN_ADDR)
                    rd_value = cur_addr;
                else if (in_window(cur_addr))
                    rd_value = mmd_mem[cur_idx];
                else
                    rd_value = 16'h0000;
            end
            REG_CTL2: rd_value = ctl2;
            default: rd_value = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= ST_PRE;
            ones <= 6'h00;
            bitcnt <= 5'h00;
            hdr <= 12'h000;
            shift <= 16'h0000;
            acc_reg <= 5'h00;
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            wr_data <= 16'h0000;
            mdio_out <= 1'b1;
            mdio_oe_n_out <= 1'b1;
        end
        else
        begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (mdc_rise)
            begin
                case (state)
                    ST_PRE:
                    begin
                        mdio_oe_n_out <= 1'b1;
                        if (mdio_s2)
                            ones <= (ones == 6'(PRE_LEN)) ? ones
                                                          : ones + 6'h01;
                        else
                        begin
                            if (ones == 6'(PRE_LEN))
                            begin
                                state <= ST_HDR;
                                bitcnt <= 5'h00;
                            end
                            ones <= 6'h00;
                        end
                    end
                    ST_HDR:
                    begin
                        hdr <= next_hdr[11:0];
                        bitcnt <= bitcnt + 5'h01;
                        if (bitcnt == 5'(HDR_BITS - 1))
                        begin
                            acc_reg <= next_hdr[4:0];
                            bitcnt <= 5'h00;
                            shift <= rd_value;
                            rd_stb <= hdr_read;
                            state <= (hdr_read || hdr_write) ? ST_TA : ST_PRE;
                        end
                    end
                    ST_TA:
                    begin
                        bitcnt <= bitcnt + 5'h01;
                        if (rd_stb || hdr[11:10] == OP_READ)
                        begin
                            // second turnaround bit is driven low
                            mdio_out <= 1'b0;
                            mdio_oe_n_out <= 1'b0;
                            bitcnt <= 5'h00;
                            state <= ST_RDATA;
                        end
                        else if (bitcnt == 5'h01)
                        begin
                            bitcnt <= 5'h00;
                            state <= ST_WDATA;
                        end
                    end
                    ST_WDATA:
                    begin
                        shift <= {shift[14:0], mdio_s2};
                        bitcnt <= bitcnt + 5'h01;
                        if (bitcnt == 5'(DATA_BITS - 1))
                        begin
                            wr_data <= {shift[14:0], mdio_s2};
                            wr_stb <= 1'b1;
                            state <= ST_PRE;
                        end
                    end
                    ST_RDATA:
                    begin
                        bitcnt <= bitcnt + 5'h01;
                        if (bitcnt == 5'(DATA_BITS))
                        begin
                            mdio_oe_n_out <= 1'b1;
                            mdio_out <= 1'b1;
                            state <= ST_PRE;
                        end
                        else
                        begin
                            mdio_out <= shift[15];
                            shift <= {shift[14:0], 1'b0};
                        end
                    end
                    default: state <= ST_PRE;
                endcase
            end
        end
    end

    // ==========================================================
    // portal registers and mmd storage
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ind_ctrl <= IND_CTRL_RST;
            for (int i = 0; i < NDEV; i++)
                ind_addr[i] <= IND_ADDR_RST;
            for (int j = 0; j < MEM_N; j++)
                mmd_mem[j] <= 16'h0000;
        end
        else if (wr_stb && acc_reg == REG_IND_CTRL)
        begin
            ind_ctrl <= wr_data;
        end
        else if (wr_stb && acc_reg == REG_IND_DATA)
        begin
            if (func == FN_ADDR)
                ind_addr[indirect_device_number] <= wr_data;
            else
            begin
                // writes outside the built window are dropped
                if (in_window(cur_addr))
                    mmd_mem[cur_idx] <= wr_data;
                // both increment functions step on writes
                if (func == FN_INC_RW || func == FN_INC_WR)
                    ind_addr[indirect_device_number] <= cur_addr + 16'h0001;
            end
        end
        // only the read-and-write function steps on reads
        else if (rd_stb && acc_reg == REG_IND_DATA && func == FN_INC_RW)
            ind_addr[indirect_device_number] <= cur_addr + 16'h0001;
    end

    // ==========================================================
    // phy control two
    logic [1:0] strap_cnt;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctl2 <= CTL2_RST;
            strap_cnt <= 2'h0;
        end
        else
        begin
            // strap caught once the synchroniser has settled
            if (strap_cnt != 2'(STRAP_WAIT))
            begin
                strap_cnt <= strap_cnt + 2'h1;
                ctl2[CTL2_XOFF] <= strap_s2;
                ctl2[CTL2_LED_LO+1:CTL2_LED_LO] <= LED_MODE_RST;
            end
            else if (wr_stb && acc_reg == REG_CTL2)
                ctl2 <= wr_data;
        end
    end

    // direct control outputs: algorithm, crossover off, force link, power save, jabber, tx off, loop, sqe, scrambler
    assign crossover_algo_select_out = ctl2[CTL2_ALGO];
    assign xover_disable_out = ctl2[CTL2_XOFF];
    assign force_link_out = ctl2[CTL2_FLINK];
    assign power_save_out = ctl2[CTL2_PSAVE];
    assign jabber_en_out = ctl2[CTL2_JAB];
    assign tx_disable_out = ctl2[CTL2_TXOFF];
    assign remote_loop_out = ctl2[CTL2_RLOOP];
    assign sqe_test_out = ctl2[CTL2_SQE];
    assign scramble_bypass_out = ctl2[CTL2_SCRB];

    // ==========================================================
    // pair select, leds, interrupt pin
    logic [1:0] led_mode;
    assign led_mode = ctl2[CTL2_LED_LO+1:CTL2_LED_LO];

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mdix_active_out <= 1'b0;
            led0_out <= 1'b0;
            led1_out <= 1'b0;
            irq_pin_out <= 1'b1;
        end
        else
        begin
            // forced pair assignment when auto crossover is off
            mdix_active_out <= ctl2[CTL2_XOFF] ? ctl2[CTL2_MDIX]
                                               : auto_mdix_in;
            // reserved modes leave both indicators off
            case (led_mode)
                LED_SPD_LNKACT:
                begin
                    led1_out <= speed_in;
                    led0_out <= link_in | activity_in;
                end
                LED_ACT_LNK:
                begin
                    led1_out <= activity_in;
                    led0_out <= link_in;
                end
                default:
                begin
                    led1_out <= 1'b0;
                    led0_out <= 1'b0;
                end
            endcase
            irq_pin_out <= ctl2[CTL2_IPOL] ? irq_event_in : ~irq_event_in;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_inc_rw_write: assert property (
        (wr_stb && acc_reg == REG_IND_DATA && func == FN_INC_RW)
        |=> cur_addr == $past(cur_addr) + 16'h0001)
        else $error("pointer did not step after data write");
    chk_inc_wr_read: assert property (
        (rd_stb && acc_reg == REG_IND_DATA && func == FN_INC_WR)
        |=> cur_addr == $past(cur_addr))
        else $error("pointer stepped on read in write-only mode");
    chk_addr_load: assert property (
        (wr_stb && acc_reg == REG_IND_DATA && func == FN_ADDR)
        |=> cur_addr == $past(wr_data))
        else $error("address function did not load pointer");
    chk_no_inc_data: assert property (
        (wr_stb && acc_reg == REG_IND_DATA && func == FN_DATA)
        |=> $stable(cur_addr))
        else $error("pointer moved without increment");
    chk_dev_select: assert property (
        (wr_stb && acc_reg == REG_IND_CTRL)
        |=> indirect_device_number == $past(wr_data[4:0]))
        else $error("device number not taken");
    chk_ctl2_write: assert property (
        (wr_stb && acc_reg == REG_CTL2 && strap_cnt == 2'(STRAP_WAIT))
        |=> ctl2 == $past(wr_data) && force_link_out == $past(wr_data[11]))
        else $error("control register write lost");
    chk_led_map: assert property (
        (led_mode == LED_ACT_LNK) |=> led1_out == $past(activity_in)
        && led0_out == $past(link_in))
        else $error("led mapping wrong");
    chk_irq_level: assert property (
        !rst_in |=> irq_pin_out
        == ($past(irq_event_in) ~^ $past(ctl2[CTL2_IPOL])))
        else $error("interrupt pin polarity wrong");
    chk_forced_pair: assert property (
        ctl2[CTL2_XOFF] |=> mdix_active_out == $past(ctl2[CTL2_MDIX]))
        else $error("forced pair assignment not applied");

endmodule : pcmp_regs

/* File: tb/pcmp_mgmt_master.sv */
// Purpose: station management master sending clause-22 frames
// Assumes: mdc period of 8 clk_in cycles, mdio wire pulled up
// Notes: mdc stands low between frames; mdio changes on mdc fall
module pcmp_mgmt_master
(
    // clock
    input wire logic clk_in,
    // management pins
    output logic mdc_out,
    output logic mdio_out,
    output logic mdio_oe_n_out,
    input wire logic mdio_in,
    // read results
    output logic rd_valid_out,
    output logic [15:0] rd_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import pcmp_pkg::*;
    logic smp;

    initial
    begin
        mdc_out = 1'b0;
        mdio_out = 1'b1;
        mdio_oe_n_out = 1'b1;
        rd_valid_out = 1'b0;
        rd_data_out = 16'h0000;
    end

    // ==========================================================
    // one mdc period, wire sampled at the rising edge
    task automatic mbit(input logic oe_n, input logic b);
        @(posedge clk_in);
        mdc_out <= 1'b0;
        mdio_oe_n_out <= oe_n;
        mdio_out <= b;
        repeat (4) @(posedge clk_in);
        mdc_out <= 1'b1;
        smp = mdio_in;
        repeat (3) @(posedge clk_in);
    endtask : mbit

    // fresh preamble before every frame, header msb first
    task automatic mhead(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] rg);
        logic [13:0] h;
        h = {2'b01, op, phy, rg};
        repeat (PRE_LEN) mbit(1'b0, 1'b1);
        for (int i = 13; i >= 0; i--)
            mbit(1'b0, h[i]);
    endtask : mhead

    task automatic write_reg(input logic [4:0] phy, input logic [4:0] rg,
                             input logic [15:0] d);
        mhead(OP_WRITE, phy, rg);
        mbit(1'b0, 1'b1);
        mbit(1'b0, 1'b0);
        for (int i = 15; i >= 0; i--)
            mbit(1'b0, d[i]);
        mbit(1'b1, 1'b0);
        @(posedge clk_in);
        mdc_out <= 1'b0;
    endtask : write_reg

    // released for turnaround and data; one extra released period
    // lets the device drop bit 0 before the next preamble
    task automatic read_reg(input logic [4:0] phy, input logic [4:0] rg);
        logic [15:0] d;
        d = 16'h0000;
        mhead(OP_READ, phy, rg);
        mbit(1'b1, 1'b0);
        mbit(1'b1, 1'b0);
        for (int i = 15; i >= 0; i--)
        begin
            mbit(1'b1, 1'b0);
            d[i] = smp;
        end
        mbit(1'b1, 1'b0);
        @(posedge clk_in);
        rd_data_out <= d;
        mdc_out <= 1'b0;
        rd_valid_out <= 1'b1;
        @(posedge clk_in);
        rd_valid_out <= 1'b0;
    endtask : read_reg
endmodule : pcmp_mgmt_master

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the control two register and portal
// Assumes: device at management address 1, led reset variant 00
// Notes: expected read values are queued by the driver, checked by a monitor
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pcmp_pkg::*;
    localparam logic [1:0] LED_RST = LED_SPD_LNKACT;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic strap = 1'b1;
    logic [4:0] st = 5'h00;
    logic mdc, m_out, m_oe_n, d_out, d_oe_n, wire_lvl, rd_valid;
    logic [15:0] rd_data, v, a, b;
    wire [12:0] pins;
    logic [15:0] exp_q[$];
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;

    always #4 clk_in = ~clk_in;
    // pulled-up wire: released by both parties reads high
    assign wire_lvl = !d_oe_n ? d_out : (!m_oe_n ? m_out : 1'b1);

    pcmp_mgmt_master u_m (.clk_in(clk_in), .mdc_out(mdc), .mdio_out(m_out),
        .mdio_oe_n_out(m_oe_n), .mdio_in(wire_lvl),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data));

    pcmp_regs #(.LED_MODE_RST(LED_RST)) dut (.clk_in(clk_in),
        .rst_in(rst_in), .mdc_in(mdc), .mdio_in(wire_lvl),
        .mdio_out(d_out), .mdio_oe_n_out(d_oe_n),
        .strap_xover_off_in(strap), .auto_mdix_in(st[4]),
        .speed_in(st[3]), .link_in(st[2]), .activity_in(st[1]),
        .irq_event_in(st[0]), .crossover_algo_select_out(pins[12]),
        .mdix_active_out(pins[11]), .xover_disable_out(pins[10]),
        .force_link_out(pins[9]), .power_save_out(pins[8]),
        .irq_pin_out(pins[7]), .jabber_en_out(pins[6]),
        .led1_out(pins[5]), .led0_out(pins[4]), .tx_disable_out(pins[3]),
        .remote_loop_out(pins[2]), .sqe_test_out(pins[1]),
        .scramble_bypass_out(pins[0]));

    // ==========================================================
    // checking
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    always @(posedge clk_in)
    begin
        if (rd_valid === 1'b1)
            cmp(rd_data, exp_q.pop_front());
    end

    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            final_report();
        end
    end

    // ==========================================================
    // stimulus
    task automatic wr(input logic [4:0] rg, input logic [15:0] d);
        u_m.write_reg(5'h01, rg, d);
    endtask : wr

    task automatic rd(input logic [4:0] rg, input logic [15:0] e);
        exp_q.push_back(e);
        u_m.read_reg(5'h01, rg);
    endtask : rd

    // new random status, then pin levels against ctl2 value c
    task automatic chk_pins(input logic [15:0] c);
        logic [1:0] led;
        logic [4:0] s;
        logic [15:0] e;
        s = 5'($urandom);
        @(posedge clk_in);
        st <= s;
        repeat (6) @(posedge clk_in);
        case (c[5:4])
            2'b00: led = {s[3], s[2] | s[1]};
            2'b01: led = {s[1], s[2]};
            default: led = 2'b00;
        endcase
        e = {3'b000, c[15], c[13] ? c[14] : s[4], c[13], c[11], c[10],
             c[9] ? s[0] : ~s[0], c[8], led, c[3:0]};
        cmp({3'b000, pins}, e);
    endtask : chk_pins

    initial
    begin
        void'($urandom(32'h42ba_f597));
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        v = CTL2_RST | 16'h2000 | {10'h000, LED_RST, 4'h0};
        rd(REG_CTL2, v);
        chk_pins(v);
        for (int i = 0; i < 6; i++)
        begin
            v = 16'($urandom);
            v[5:4] = i[1:0];
            v[13] = i[0];
            wr(REG_CTL2, v);
            chk_pins(v);
            rd(REG_CTL2, v);
        end
        // wrong management address is ignored, line stays released
        u_m.write_reg(5'h02, REG_CTL2, ~v);
        rd(REG_CTL2, v);
        exp_q.push_back(16'hffff);
        u_m.read_reg(5'h02, REG_CTL2);
        wr(5'h05, 16'h1234);
        rd(5'h05, 16'h0000);
        a = 16'($urandom);
        b = 16'($urandom);
        // single write then non-stepping reads
        wr(REG_IND_CTRL, 16'h0007);
        wr(REG_IND_DATA, 16'h0003);
        wr(REG_IND_CTRL, 16'h4007);
        wr(REG_IND_DATA, v);
        rd(REG_IND_DATA, v);
        rd(REG_IND_DATA, v);
        // step on writes only
        wr(REG_IND_CTRL, 16'h001f);
        wr(REG_IND_DATA, 16'h0005);
        wr(REG_IND_CTRL, 16'hc01f);
        wr(REG_IND_DATA, a);
        wr(REG_IND_DATA, b);
        rd(REG_IND_DATA, 16'h0000);
        rd(REG_IND_DATA, 16'h0000);
        // burst read stepping on reads
        wr(REG_IND_CTRL, 16'h001f);
        wr(REG_IND_DATA, 16'h0005);
        wr(REG_IND_CTRL, 16'h801f);
        rd(REG_IND_DATA, a);
        rd(REG_IND_DATA, b);
        rd(REG_IND_DATA, 16'h0000);
        // a write outside the window is dropped but still steps: 8 to 9
        wr(REG_IND_DATA, a);
        wr(REG_IND_CTRL, 16'h001f);
        rd(REG_IND_DATA, 16'h0009);
        // device 7 kept its own pointer; write-only mode holds on reads
        wr(REG_IND_CTRL, 16'hc007);
        rd(REG_IND_CTRL, 16'hc007);
        rd(REG_IND_DATA, v);
        rd(REG_IND_DATA, v);
        wr(REG_IND_CTRL, 16'h0007);
        rd(REG_IND_DATA, 16'h0003);
        // mid-run reset with the strap low: bit 13 follows it
        @(posedge clk_in);
        strap <= 1'b0;
        rst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        v = CTL2_RST | {10'h000, LED_RST, 4'h0};
        rd(REG_CTL2, v);
        chk_pins(v);
        rd(REG_IND_DATA, 16'h0000);
        repeat (10) @(posedge clk_in);
        cmp(16'(exp_q.size()), 16'h0000);
        final_report();
    end
endmodule : tb_top
